// ### hsf_pkg.sv
// package: register map, field layout and timing constants of the hvac status and fire block
package hsf_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] HSF_OFF_ALARM_DELAY = 8'h00;
    localparam logic [7:0] HSF_OFF_STATUS = 8'h04;
    localparam logic [7:0] HSF_OFF_FIRE_CFG = 8'h08;
    localparam logic [7:0] HSF_OFF_LEVEL_CFG = 8'h0c;
    localparam logic [7:0] HSF_OFF_FIRE_SETPOINT = 8'h10;
    localparam logic [7:0] HSF_OFF_AUTORESET = 8'h14;
    localparam logic [7:0] HSF_OFF_EVENTS = 8'h18;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [15:0] HSF_DELAY_RST = 16'h01f4;
    localparam logic [2:0] HSF_FIRE_CFG_RST = 3'h0;
    localparam logic [1:0] HSF_LEVEL_CFG_RST = 2'h0;
    localparam logic [15:0] HSF_SETPOINT_RST = 16'h0000;

    // --------------------------------------------------------------
    // status word bit positions
    // --------------------------------------------------------------
    localparam int HSF_ST_FIRE = 0;
    localparam int HSF_ST_BYPASS = 1;
    localparam int HSF_ST_SHORT_CYCLE = 2;
    localparam int HSF_ST_DRY_PUMP = 3;
    localparam int HSF_ST_BROKEN_BELT = 4;
    localparam int HSF_ST_FILTER = 5;
    localparam int HSF_ST_MAIN_MANUAL = 6;
    localparam int HSF_ST_SLEEP = 7;
    localparam int HSF_ST_EXT_MANUAL = 8;
    localparam int HSF_ST_USED = 9;

    // --------------------------------------------------------------
    // configuration encodings
    // --------------------------------------------------------------
    localparam logic [1:0] HSF_LVL_DISABLE = 2'h0;
    localparam logic [1:0] HSF_LVL_ALARM = 2'h1;
    localparam logic [1:0] HSF_LVL_FAULT = 2'h2;
    localparam logic [2:0] HSF_FIRE_OFF = 3'h0;
    localparam logic [2:0] HSF_FIRE_KEEP = 3'h1;
    localparam logic [2:0] HSF_FIRE_MAXSPD = 3'h2;
    localparam logic [2:0] HSF_FIRE_SETPT = 3'h3;
    localparam logic [2:0] HSF_FIRE_COAST = 3'h4;

    // --------------------------------------------------------------
    // timing: delay register counts 10 ms units
    // --------------------------------------------------------------
    localparam int HSF_CLK_HZ = 25_000_000;
    localparam int HSF_DELAY_UNIT_MS = 10;
    localparam int HSF_UNIT_CYC = HSF_CLK_HZ / 1000 * HSF_DELAY_UNIT_MS;
    localparam int HSF_RESET_WAIT_MS = 1000;
    localparam int HSF_RESET_WAIT_CYC = HSF_CLK_HZ / 1000 * HSF_RESET_WAIT_MS;

    // --------------------------------------------------------------
    // grouped signals
    // --------------------------------------------------------------
    typedef struct packed {
        logic bypass;
        logic short_cycle;
        logic dry_pump;
        logic broken_belt;
        logic filter;
        logic main_manual;
        logic sleep;
        logic ext_manual;
    } hsf_flags_t;

    typedef struct packed {
        logic speed_max;
        logic use_fire_setpoint;
        logic pulse_disable;
        logic ignore_stop;
        logic fire_output;
    } hsf_drive_t;

    typedef enum logic [1:0] {
        HSF_LV_IDLE,
        HSF_LV_ALARM,
        HSF_LV_DECEL,
        HSF_LV_FAULT
    } hsf_level_st_t;
endpackage

// ### hsf_tick.sv
// tick generator: one pulse per period of a given number of clocks
`timescale 1ns/1ps
module hsf_tick
    import hsf_pkg::*;
#(
    parameter int PERIOD = HSF_UNIT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    output logic o_tick
);
    typedef struct packed {
        logic [27:0] cnt;
        logic tick;
    } hsf_tick_st_t;

    hsf_tick_st_t st_reg;
    hsf_tick_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!i_run) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt == 28'(PERIOD - 1)) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 28'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;
endmodule

// ### hsf_core.sv
// top: high level alarm timing, hvac status word and fire mode supervisor with apb slave
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps

// Contract
// (RQ1) high alarm rises after high level persists for the programmed delay
// (RQ2) level config 2 also raises fault, only once the motor has stopped
// (RQ3) a zero delay disables high level detection
// (RQ4) read only 16-bit status word, bits 9 to 15 reserved
// (RQ5) bit 0 shows fire mode
// (RQ6) bit 1 shows bypass mode
// (RQ7) bit 2 shows short cycle protection active
// (RQ8) bit 3 shows dry pump detected
// (RQ9) bit 4 shows broken belt detected
// (RQ10) bit 5 shows filter maintenance alarm
// (RQ11) bit 6 is 1 when main controller is manual
// (RQ12) bit 7 shows sleep mode
// (RQ13) bit 8 is 1 when external controller is manual
// (RQ14) fire mode entered when assigned input is low
// (RQ15) entering fire raises fire alarm, state indication and fire output
// (RQ16) in fire mode every stop command, even general enable, is ignored
// (RQ17) overvoltage and overcurrent faults stay active in fire mode, auto-reset eligible
// (RQ18) fire config 0 keeps fire mode inactive
// (RQ19) fire config 1 leaves reference and setpoint unchanged
// (RQ20) fire config 2 forces speed reference to maximum
// (RQ21) fire config 3 substitutes the dedicated fire setpoint
// (RQ22) fire config 4 disables output pulses, motor coasts
// (RQ23) fire setpoint is used while fire active with config 3
// (RQ24) unlimited policy resets a critical fault one second after detection
// (RQ25) level config 1 only signals the alarm, drive keeps running
// (RQ26) reserved status bits read zero and ignore writes
module hsf_core
    import hsf_pkg::*;
#(
    parameter int RESET_WAIT_CYC = HSF_RESET_WAIT_CYC,
    parameter int UNIT_CYC = HSF_UNIT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_assigned_digital_input,
    input wire logic i_high_level,
    input wire logic i_motor_stopped,
    input wire logic i_stop_cmd,
    input wire logic i_general_enable,
    input wire logic i_dc_overvoltage_fault,
    input wire logic i_overcurrent_fault,
    input wire hsf_flags_t i_flags,
    output logic o_high_level_alarm,
    output logic o_high_level_fault,
    output logic o_high_level_decel,
    output logic o_fire_alarm,
    output logic o_drive_state_fire,
    output hsf_drive_t o_drive,
    output logic o_run_stop,
    output logic o_enable_out,
    output logic [15:0] o_fire_setpoint,
    output logic o_critical_fault,
    output logic o_critical_autoreset
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] delay;
        logic [2:0] fire_cfg;
        logic [1:0] level_cfg;
        logic [15:0] setpoint;
        logic autoreset;
        logic [15:0] level_cnt;
        hsf_level_st_t level_st;
        logic fire;
        logic [31:0] crit_cnt;
        logic crit_latched;
        logic crit_reset;
        logic fire_seen;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic alarm;
        logic fault;
        logic decel;
        hsf_drive_t drive;
        logic run_stop;
        logic enable_out;
    } hsf_state_t;

    hsf_state_t st_reg;
    hsf_state_t st_next;
    logic unit_tick;
    logic high_armed;
    logic [15:0] status_word;

    function automatic logic known_addr(input logic [7:0] a);
        return a == HSF_OFF_ALARM_DELAY || a == HSF_OFF_STATUS || a == HSF_OFF_FIRE_CFG
            || a == HSF_OFF_LEVEL_CFG || a == HSF_OFF_FIRE_SETPOINT
            || a == HSF_OFF_AUTORESET || a == HSF_OFF_EVENTS;
    endfunction

    // ------------------------------------------------------------------
    // 10 ms time base for the alarm delay
    // ------------------------------------------------------------------
    assign high_armed = i_high_level && st_reg.delay != 16'h0000
        && st_reg.level_cfg != HSF_LVL_DISABLE; // RQ3

    hsf_tick #(
        .PERIOD(UNIT_CYC)
    ) u_tick (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(high_armed),
        .o_tick(unit_tick)
    );

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    always_comb begin
        status_word = '0; // RQ26 RQ4
        status_word[HSF_ST_FIRE] = st_reg.fire; // RQ5
        status_word[HSF_ST_BYPASS] = i_flags.bypass; // RQ6
        status_word[HSF_ST_SHORT_CYCLE] = i_flags.short_cycle; // RQ7
        status_word[HSF_ST_DRY_PUMP] = i_flags.dry_pump; // RQ8
        status_word[HSF_ST_BROKEN_BELT] = i_flags.broken_belt; // RQ9
        status_word[HSF_ST_FILTER] = i_flags.filter; // RQ10
        status_word[HSF_ST_MAIN_MANUAL] = i_flags.main_manual; // RQ11
        status_word[HSF_ST_SLEEP] = i_flags.sleep; // RQ12
        status_word[HSF_ST_EXT_MANUAL] = i_flags.ext_manual; // RQ13
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.ready = 1'b0;
        st_next.slverr = 1'b0;

        // apb slave: one wait state, answer on the second access cycle
        if (psel && penable && !st_reg.ready) begin
            st_next.ready = 1'b1;
            st_next.slverr = !known_addr(paddr);
            st_next.rdata = '0;
            if (pwrite) begin
                unique case (paddr)
                    HSF_OFF_ALARM_DELAY: st_next.delay = pwdata[15:0];
                    HSF_OFF_FIRE_CFG: st_next.fire_cfg = pwdata[2:0];
                    HSF_OFF_LEVEL_CFG: st_next.level_cfg = pwdata[1:0];
                    HSF_OFF_FIRE_SETPOINT: st_next.setpoint = pwdata[15:0];
                    HSF_OFF_AUTORESET: st_next.autoreset = pwdata[0];
                    default: st_next.slverr = st_next.slverr || paddr == HSF_OFF_STATUS; // RQ26
                endcase
            end else begin
                unique case (paddr)
                    HSF_OFF_ALARM_DELAY: st_next.rdata = {16'h0000, st_reg.delay};
                    HSF_OFF_STATUS: st_next.rdata = {16'h0000, status_word}; // RQ4
                    HSF_OFF_FIRE_CFG: st_next.rdata = {29'h0, st_reg.fire_cfg};
                    HSF_OFF_LEVEL_CFG: st_next.rdata = {30'h0, st_reg.level_cfg};
                    HSF_OFF_FIRE_SETPOINT: st_next.rdata = {16'h0000, st_reg.setpoint};
                    HSF_OFF_AUTORESET: st_next.rdata = {31'h0, st_reg.autoreset};
                    HSF_OFF_EVENTS: st_next.rdata = {28'h0, st_reg.fire_seen,
                        st_reg.crit_latched, st_reg.fault, st_reg.alarm};
                    default: st_next.rdata = '0;
                endcase
            end
            if (!pwrite && paddr == HSF_OFF_EVENTS) begin
                st_next.fire_seen = 1'b0;
            end
        end

        // high level alarm timing
        if (!high_armed) begin
            st_next.level_cnt = '0;
        end else if (unit_tick && st_reg.level_cnt != st_reg.delay) begin
            st_next.level_cnt = st_reg.level_cnt + 16'h1; // RQ1
        end
        unique case (st_reg.level_st)
            HSF_LV_IDLE: begin
                if (high_armed && st_reg.level_cnt == st_reg.delay) begin
                    st_next.level_st = st_reg.level_cfg == HSF_LVL_FAULT
                        ? HSF_LV_DECEL : HSF_LV_ALARM; // RQ1 RQ2 RQ25
                end
            end
            HSF_LV_ALARM: begin
                if (!high_armed) begin
                    st_next.level_st = HSF_LV_IDLE;
                end
            end
            HSF_LV_DECEL: begin
                if (i_motor_stopped) begin
                    st_next.level_st = HSF_LV_FAULT; // RQ2
                end
            end
            HSF_LV_FAULT: begin
                if (st_reg.level_cfg != HSF_LVL_FAULT) begin
                    st_next.level_st = HSF_LV_IDLE;
                end
            end
        endcase
        st_next.alarm = st_next.level_st != HSF_LV_IDLE; // RQ1 RQ25
        st_next.decel = st_next.level_st == HSF_LV_DECEL; // RQ2
        st_next.fault = st_next.level_st == HSF_LV_FAULT; // RQ2

        // fire mode supervisor
        st_next.fire = st_reg.fire_cfg != HSF_FIRE_OFF
            && st_reg.fire_cfg <= HSF_FIRE_COAST
            && !i_assigned_digital_input; // RQ14 RQ18
        if (st_next.fire) begin
            st_next.fire_seen = 1'b1; // RQ15
        end
        st_next.drive.fire_output = st_next.fire; // RQ15
        st_next.drive.ignore_stop = st_next.fire; // RQ16
        st_next.drive.speed_max = st_next.fire
            && st_reg.fire_cfg == HSF_FIRE_MAXSPD; // RQ20
        st_next.drive.use_fire_setpoint = st_next.fire
            && st_reg.fire_cfg == HSF_FIRE_SETPT; // RQ21 RQ23
        st_next.drive.pulse_disable = st_next.fire
            && st_reg.fire_cfg == HSF_FIRE_COAST; // RQ22
        // keep mode changes no reference, but run is still forced on as in every fire mode
        st_next.run_stop = st_next.fire ? 1'b1 : !i_stop_cmd; // RQ16 RQ19
        st_next.enable_out = st_next.fire
            ? !st_next.drive.pulse_disable : i_general_enable; // RQ16 RQ22

        // critical faults stay live; timed unlimited reset in fire mode
        st_next.crit_reset = 1'b0;
        if (i_dc_overvoltage_fault || i_overcurrent_fault) begin
            st_next.crit_latched = 1'b1; // RQ17
        end
        if (st_reg.crit_latched && st_reg.fire && st_reg.autoreset) begin
            if (st_reg.crit_cnt == 32'(RESET_WAIT_CYC - 1)) begin
                st_next.crit_cnt = '0;
                st_next.crit_reset = 1'b1; // RQ24
                st_next.crit_latched = i_dc_overvoltage_fault || i_overcurrent_fault;
            end else begin
                st_next.crit_cnt = st_reg.crit_cnt + 32'h1;
            end
        end else begin
            st_next.crit_cnt = '0;
            if (!i_dc_overvoltage_fault && !i_overcurrent_fault && !st_reg.fire) begin
                st_next.crit_latched = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
            st_reg.delay <= HSF_DELAY_RST;
            st_reg.fire_cfg <= HSF_FIRE_CFG_RST;
            st_reg.level_cfg <= HSF_LEVEL_CFG_RST;
            st_reg.setpoint <= HSF_SETPOINT_RST;
            st_reg.level_st <= HSF_LV_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.slverr;
    assign o_high_level_alarm = st_reg.alarm;
    assign o_high_level_fault = st_reg.fault;
    assign o_high_level_decel = st_reg.decel;
    assign o_fire_alarm = st_reg.fire; // RQ15
    assign o_drive_state_fire = st_reg.fire; // RQ15
    assign o_drive = st_reg.drive;
    assign o_run_stop = st_reg.run_stop;
    assign o_enable_out = st_reg.enable_out;
    assign o_fire_setpoint = st_reg.setpoint; // RQ23
    assign o_critical_fault = st_reg.crit_latched; // RQ17
    assign o_critical_autoreset = st_reg.crit_reset;
endmodule

// ### hsf_core_monitor.sv
// checker: concurrent properties on the ports of the hvac status and fire block
`timescale 1ns/1ps
module hsf_core_monitor
    import hsf_pkg::*;
#(
    parameter int RESET_WAIT_CYC = HSF_RESET_WAIT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic i_assigned_digital_input,
    input wire logic i_stop_cmd,
    input wire logic i_general_enable,
    input wire logic i_motor_stopped,
    input wire logic o_high_level_alarm,
    input wire logic o_high_level_fault,
    input wire logic o_fire_alarm,
    input wire logic o_drive_state_fire,
    input wire hsf_drive_t o_drive,
    input wire logic o_run_stop,
    input wire logic o_enable_out,
    input wire logic o_critical_fault,
    input wire logic o_critical_autoreset
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    a_fire_entry: assert property ($rose(o_fire_alarm) |-> !$past(i_assigned_digital_input))
        else $error("fire mode entered without low input");
    a_fire_state: assert property (o_fire_alarm == o_drive_state_fire)
        else $error("state indication differs from fire alarm");
    a_stop_ignored: assert property (o_fire_alarm |-> o_run_stop && o_drive.ignore_stop)
        else $error("stop honoured in fire mode");
    a_run_follow: assert property ($past(i_rst_b) && !$past(o_fire_alarm) && !o_fire_alarm
        |-> o_run_stop == !$past(i_stop_cmd))
        else $error("run output does not follow stop command");
    a_enable_follow: assert property ($past(i_rst_b) && !$past(o_fire_alarm) && !o_fire_alarm
        |-> o_enable_out == $past(i_general_enable))
        else $error("enable output does not follow general enable");
    a_coast_pulses: assert property ($past(o_fire_alarm) && o_fire_alarm
        |-> o_enable_out == !o_drive.pulse_disable)
        else $error("pulse enable wrong in fire mode");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_status_ro: assert property (psel && penable && !pready && pwrite
        && paddr == HSF_OFF_STATUS |=> pslverr)
        else $error("status write not refused");
    a_fault_stop: assert property ($rose(o_high_level_fault) |-> $past(i_motor_stopped))
        else $error("level fault before motor stopped");
    a_fault_alarm: assert property (o_high_level_fault |-> o_high_level_alarm)
        else $error("level fault without alarm");
    a_reset_cause: assert property (o_critical_autoreset
        |-> $past(o_critical_fault) && $past(o_fire_alarm))
        else $error("auto reset without latched fault in fire mode");
    a_reset_pulse: assert property (o_critical_autoreset |=> !o_critical_autoreset)
        else $error("auto reset longer than one cycle");
    c_fire: cover property ($rose(o_fire_alarm));
    c_autoreset: cover property (o_critical_autoreset);
    c_fault: cover property ($rose(o_high_level_fault));
endmodule

bind hsf_core hsf_core_monitor #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) i_hsf_core_monitor (
    .i_ref_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .i_assigned_digital_input, .i_stop_cmd, .i_general_enable, .i_motor_stopped,
    .o_high_level_alarm, .o_high_level_fault, .o_fire_alarm, .o_drive_state_fire,
    .o_drive, .o_run_stop, .o_enable_out, .o_critical_fault, .o_critical_autoreset
);

// ### hsf_plant.sv
// partner model: fire input terminal, process sensor and a motor that spins up and down
`timescale 1ns/1ps
module hsf_plant (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_fire_req,
    input wire logic i_pv_high,
    input wire logic i_enable_out,
    input wire logic i_run_stop,
    input wire logic i_decel,
    output logic o_fire_in,
    output logic o_high_level,
    output logic o_motor_stopped
);
    logic [3:0] speed_reg;
    assign o_fire_in = !i_fire_req;
    assign o_high_level = i_pv_high;
    assign o_motor_stopped = (speed_reg == 4'h0);
    // motor ramps while driven, coasts down otherwise
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            speed_reg <= 4'h0;
        end else if (i_enable_out && i_run_stop && !i_decel) begin
            speed_reg <= (speed_reg == 4'hf) ? speed_reg : speed_reg + 4'h1;
        end else if (speed_reg != 4'h0) begin
            speed_reg <= speed_reg - 4'h1;
        end
    end
endmodule

// ### tb_hsf_core.sv
// testbench: register access, status word, fire behaviours, critical reset and level alarm
`timescale 1ns/1ps
module tb_hsf_core;
    import hsf_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, fire_req, pv_high, fire_in;
    logic high_level, stopped, stop_cmd, gen_en, ov, oc, alarm, fault, decel, fire_alarm;
    logic state_fire, run_stop, enable_out, crit, crit_rst, rerr, seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] fire_sp;
    hsf_flags_t flags;
    hsf_drive_t drive;
    int fails = 0;
    int comparisons = 0;
    int n;
    // shortened alarm time base keeps the run small
    localparam int UNIT = 1000;
    hsf_core #(.RESET_WAIT_CYC(20), .UNIT_CYC(UNIT)) i_hsf_core (.i_ref_clk(clk),
        .i_rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_assigned_digital_input(fire_in), .i_high_level(high_level),
        .i_motor_stopped(stopped), .i_stop_cmd(stop_cmd), .i_general_enable(gen_en),
        .i_dc_overvoltage_fault(ov), .i_overcurrent_fault(oc), .i_flags(flags),
        .o_high_level_alarm(alarm), .o_high_level_fault(fault), .o_high_level_decel(decel),
        .o_fire_alarm(fire_alarm), .o_drive_state_fire(state_fire), .o_drive(drive),
        .o_run_stop(run_stop), .o_enable_out(enable_out), .o_fire_setpoint(fire_sp),
        .o_critical_fault(crit), .o_critical_autoreset(crit_rst));
    hsf_plant i_hsf_plant (.i_ref_clk(clk), .i_rst_b(rst_b), .i_fire_req(fire_req),
        .i_pv_high(pv_high), .i_enable_out(enable_out), .i_run_stop(run_stop),
        .i_decel(decel || fault), .o_fire_in(fire_in), .o_high_level(high_level),
        .o_motor_stopped(stopped));
    always #20 clk = ~clk;
    // --------------------------------------------------------------
    // bus and check helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fails++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400_000;
        fails++;
        wrap_up();
    end
    initial begin
        logic f;
        {clk, rst_b, psel, penable, pwrite, paddr, pwdata, flags} = '0;
        {fire_req, pv_high, stop_cmd, ov, oc} = '0;
        gen_en = 1'b1;
        cyc(5);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(0, HSF_OFF_ALARM_DELAY, 0); chk(rdata, 32'h1f4);
        apb(0, HSF_OFF_FIRE_CFG, 0); chk(rdata, 32'h0);
        apb(0, HSF_OFF_STATUS, 0); chk(rdata, 32'h0);
        for (int i = 0; i < 8; i++) begin
            flags <= hsf_flags_t'(8'h01 << i);
            cyc(2);
            apb(0, HSF_OFF_STATUS, 0); chk(rdata, 32'h1 << (8 - i));
        end
        flags <= hsf_flags_t'(8'hff);
        apb(1, HSF_OFF_STATUS, 32'hffff); chk(32'(rerr), 32'h1);
        apb(0, HSF_OFF_STATUS, 0); chk(rdata, 32'h1fe);
        apb(0, 8'h1c, 0); chk({rerr, rdata[30:0]}, 32'h80000000);
        flags <= '0;
        stop_cmd <= 1'b1;
        gen_en <= 1'b0;
        apb(1, HSF_OFF_FIRE_SETPOINT, 32'h1234);
        for (int c = 0; c < 6; c++) begin
            f = (c >= 1 && c <= 4);
            apb(1, HSF_OFF_FIRE_CFG, 32'(c));
            fire_req <= 1'b1;
            cyc(3);
            chk(32'(fire_alarm), 32'(f));
            chk(32'(drive), 32'({c == 2, c == 3, c == 4, f, f} & {5{f}}));
            chk(32'(run_stop), 32'(f));
            chk(32'(enable_out), 32'(f && c != 4));
            apb(0, HSF_OFF_STATUS, 0); chk(rdata, 32'(f));
            fire_req <= 1'b0;
            cyc(3);
            chk(32'(fire_alarm), 32'h0);
        end
        chk(32'(fire_sp), 32'h1234);
        apb(0, HSF_OFF_EVENTS, 0); chk(rdata, 32'h8);
        apb(0, HSF_OFF_EVENTS, 0); chk(rdata, 32'h0);
        gen_en <= 1'b1;
        stop_cmd <= 1'b0;
        apb(1, HSF_OFF_FIRE_CFG, 32'h1);
        fire_req <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            apb(1, HSF_OFF_AUTORESET, 32'(1 - k));
            if (k == 0) ov <= 1'b1;
            else oc <= 1'b1;
            cyc(2);
            chk(32'(crit), 32'h1);
            seen = 1'b0;
            repeat (100) begin
                @(posedge clk);
                if (crit_rst === 1'b1) seen = 1'b1;
            end
            chk(32'(seen), 32'(1 - k));
            ov <= 1'b0;
            oc <= 1'b0;
            cyc(2);
        end
        fire_req <= 1'b0;
        apb(1, HSF_OFF_ALARM_DELAY, 0);
        apb(1, HSF_OFF_LEVEL_CFG, 32'h2);
        pv_high <= 1'b1;
        cyc(300);
        chk(32'(alarm), 32'h0);
        apb(1, HSF_OFF_ALARM_DELAY, 32'h1);
        n = 0;
        while (alarm !== 1'b1 && n < 2 * UNIT) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= UNIT - 10 && n <= UNIT + 10), 32'h1);
        n = 0;
        while (fault !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(32'({fault, stopped}), 32'h3);
        apb(1, HSF_OFF_LEVEL_CFG, 32'h1);
        cyc(2);
        chk(32'({alarm, decel, fault}), 32'h4);
        pv_high <= 1'b0;
        cyc(4);
        chk(32'({alarm, fault}), 32'h0);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(0, HSF_OFF_ALARM_DELAY, 0); chk(rdata, 32'(HSF_DELAY_RST));
        apb(0, HSF_OFF_LEVEL_CFG, 0); chk(rdata, 32'(HSF_LEVEL_CFG_RST));
        wrap_up();
    end
endmodule
